/* File: usb_fn_pkg.sv */
// Constants, register map and field layout of the low-speed function block
package usb_fn_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_DMA_HIGH  = 8'h00;
	localparam logic [7:0] OFS_DMA_LOW   = 8'h04;
	localparam logic [7:0] OFS_TOKEN     = 8'h08;
	localparam logic [7:0] OFS_FLAGS     = 8'h0C;
	localparam logic [7:0] OFS_MASK      = 8'h10;
	localparam logic [7:0] OFS_CONTROL   = 8'h14;
	localparam logic [7:0] OFS_NODE_ID   = 8'h18;
	localparam logic [7:0] OFS_EP0_TX    = 8'h1C;
	localparam logic [7:0] OFS_EP1_TX    = 8'h20;
	localparam logic [7:0] OFS_EP2_TX    = 8'h24;
	localparam int         NUM_EP        = 3;
	// Event flag bit positions
	localparam int FLG_IDLE    = 7;
	localparam int FLG_DMA     = 6;
	localparam int FLG_OK      = 5;
	localparam int FLG_ERR     = 4;
	localparam int FLG_OVR     = 3;
	localparam int FLG_WAKE    = 2;
	localparam int FLG_RESET   = 1;
	localparam int FLG_SOF     = 0;
	// Control bit positions
	localparam int CTL_RESUME  = 3;
	localparam int CTL_REGULATOR_OFF    = 2;
	localparam int CTL_SLEEP   = 1;
	localparam int CTL_FORCED_BUS_RESET    = 0;
	// Reset values
	localparam logic [7:0] RST_FLAGS   = 8'h00;
	localparam logic [7:0] RST_MASK    = 8'h00;
	localparam logic [3:0] RST_CONTROL = 4'h6;
	localparam logic [6:0] RST_NODE_ID = 7'h00;
	localparam logic [7:0] RST_EP_TX   = 8'h00;
	localparam logic [7:0] RST_DMA     = 8'h00;
	// Transmit status codes and token codes
	localparam logic [1:0] STAT_NAK    = 2'h2;
	localparam logic [1:0] PID_IN      = 2'h2;
	localparam logic [1:0] PID_SETUP   = 2'h3;
	localparam logic [1:0] PID_LOW     = 2'h1;
	// Timing: idle limit and late DMA limit
	localparam int IDLE_TIME_US   = 3000;
	localparam int CLK_MHZ        = 20;
	localparam int IDLE_CYCLES    = IDLE_TIME_US * CLK_MHZ;
	localparam logic [3:0] DMA_WAIT_CYCLES = 4'h8;
	localparam int BUF_MAX_BYTES  = 48;
endpackage : usb_fn_pkg

/* File: flag_bus_if.sv */
// Interface carrying flag set, clear and state between the flag bank and top
interface flag_bus_if;
	logic [7:0] set;
	logic [7:0] clr;
	logic [7:0] flags;
	modport owner (input set, input clr, output flags);
	modport user  (output set, output clr, input flags);
endinterface : flag_bus_if

/* File: event_flag_bank.sv */
// Sticky event flags: hardware sets, a written zero clears
module event_flag_bank
	import usb_fn_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Flag traffic
	flag_bus_if.owner fb
);
	// Set beats clear so an event in the clearing cycle survives
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fb.flags <= RST_FLAGS;
		else
			fb.flags <= (fb.flags & ~fb.clr) | fb.set;
	end

	property p_no_soft_set;
		@(posedge pclk) disable iff (!presetn)
		(fb.set == 8'h00) |=> ((fb.flags & ~$past(fb.flags)) == 8'h00);
	endproperty
	a_no_soft_set: assert property (p_no_soft_set)
		else $error("flag rose without a hardware event");
endmodule : event_flag_bank

/* File: idle_detector.sv */
// Counts continuous idle bus time and pulses once past the limit
module idle_detector
	import usb_fn_pkg::*;
#(
	parameter int LIMIT = IDLE_CYCLES
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Qualifiers
	input wire logic armed,
	input wire logic idle_line,
	// Result
	output logic     hit
);
	logic [16:0] count;

	// Saturating count; any activity or disarm restarts it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= 17'h00000;
			hit   <= 1'b0;
		end
		else if (!(armed && idle_line))
		begin
			count <= 17'h00000;
			hit   <= 1'b0;
		end
		else
		begin
			hit <= (count == 17'(LIMIT));
			if (count <= 17'(LIMIT))
				count <= count + 17'h00001;
		end
	end

	property p_hit_needs_idle;
		@(posedge pclk) disable iff (!presetn)
		hit |-> $past(armed && idle_line) && $past(count) == 17'(LIMIT);
	endproperty
	a_hit_needs_idle: assert property (p_hit_needs_idle)
		else $error("idle pulse without the full idle time");
endmodule : idle_detector

/* File: usb_fn_regs.sv */
// Register and event logic of the low-speed function interface
module usb_fn_regs
	import usb_fn_pkg::*;
#(
	parameter int IDLE_LIMIT = IDLE_CYCLES
)(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Transceiver line pins
	input  wire logic        line_se0_pin,
	input  wire logic        line_k_pin,
	// Serial engine report
	input  wire logic        xfer_done,
	input  wire logic [1:0]  xfer_ep,
	input  wire logic [1:0]  xfer_pid_high,
	input  wire logic [3:0]  xfer_count,
	input  wire logic        xfer_is_rx,
	input  wire logic        fault_pid,
	input  wire logic        fault_crc,
	input  wire logic        fault_toggle,
	input  wire logic        fault_overrun,
	input  wire logic        fault_stuff,
	input  wire logic        fault_frame,
	input  wire logic        fault_timeout,
	input  wire logic        answered_nak_stall,
	input  wire logic        keepalive,
	input  wire logic        bus_reset_seen,
	// DMA engine
	input  wire logic [5:0]  dma_offset,
	input  wire logic        dma_request,
	input  wire logic        dma_grant,
	output logic [15:0]      dma_addr,
	// Processor
	input  wire logic        cpu_imask,
	output logic             irq_req,
	output logic             wake_irq,
	// Link control outputs
	output logic             resume_drive,
	output logic             regulator_off,
	output logic             suspended,
	output logic             iface_reset,
	output logic [6:0]       node_id,
	output logic [23:0]      ep_tx_ctrl
);
	typedef enum logic [2:0] {
		ST_ACTIVE = 3'b001,
		ST_SLEEP  = 3'b010,
		ST_RESET  = 3'b100
	} link_state_t;

	link_state_t state;
	link_state_t next_state;
	logic [7:0]  dma_base_high_reg;
	logic [1:0]  buffer_base_bits;
	logic [1:0]  endpoint_number;
	logic [3:0]  received_byte_count;
	logic [1:0]  token_pid_high;
	logic [7:0]  event_mask_reg;
	logic [3:0]  link_control_reg;
	logic [6:0]  node_id_reg;
	logic [7:0]  tx_endpoint_control_reg [NUM_EP];
	logic [1:0]  se0_sync;
	logic [1:0]  k_sync;
	logic        line_se0;
	logic        line_k;
	logic        idle_armed;
	logic        idle_hit;
	logic        resume_prev;
	logic        resume_end;
	logic        activity;
	logic [3:0]  dma_wait;
	logic        dma_late_evt;
	logic        ok_evt;
	logic        err_evt;
	logic        usb_reset_evt;
	logic        sof_evt;
	logic        wake_evt;
	logic        wr_access;
	logic        rd_setup;
	logic [7:0]  wdata;
	logic [31:0] next_rdata;
	logic        next_err;

	flag_bus_if fb ();

	event_flag_bank u_flags (
		.pclk    (pclk),
		.presetn (presetn),
		.fb      (fb)
	);

	idle_detector #(.LIMIT(IDLE_LIMIT)) u_idle (
		.pclk      (pclk),
		.presetn   (presetn),
		.armed     (idle_armed),
		.idle_line (!line_se0 && !line_k),
		.hit       (idle_hit)
	);

	// Map a byte offset to an endpoint slot, 3 means none
	function automatic logic [1:0] ep_slot(input logic [7:0] a);
		case (a)
			OFS_EP0_TX: ep_slot = 2'h0;
			OFS_EP1_TX: ep_slot = 2'h1;
			OFS_EP2_TX: ep_slot = 2'h2;
			default:    ep_slot = 2'h3;
		endcase
	endfunction : ep_slot

	// Write lands at the access edge; setup edge prepares the answer
	assign wr_access = psel && penable && pwrite && pready;
	assign rd_setup  = psel && !penable;
	assign wdata     = pwdata[7:0];

	// Pins cross into the clock domain through two flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			se0_sync <= 2'h0;
			k_sync   <= 2'h0;
		end
		else
		begin
			se0_sync <= {se0_sync[0], line_se0_pin};
			k_sync   <= {k_sync[0], line_k_pin};
		end
	end
	assign line_se0 = se0_sync[1];
	assign line_k   = k_sync[1];
	assign activity = line_se0 || line_k;

	// Event sources
	assign ok_evt = xfer_done && !answered_nak_stall && !(fault_pid
		|| fault_crc || fault_toggle || fault_overrun || fault_stuff
		|| fault_frame);
	assign err_evt = fault_timeout || (xfer_done && (fault_crc
		|| fault_stuff || fault_frame));
	assign resume_end = resume_prev && !link_control_reg[CTL_RESUME];
	assign sof_evt    = keepalive || resume_end;
	assign usb_reset_evt = bus_reset_seen
		|| (state == ST_RESET && next_state != ST_RESET);
	assign wake_evt   = (state == ST_SLEEP) && activity;

	always_comb
	begin
		fb.set = 8'h00;
		fb.set[FLG_IDLE]  = idle_hit;
		fb.set[FLG_DMA]   = dma_late_evt;
		fb.set[FLG_OK]    = ok_evt;
		fb.set[FLG_ERR]   = err_evt;
		fb.set[FLG_OVR]   = (err_evt && fb.flags[FLG_ERR])
			|| (sof_evt && fb.flags[FLG_SOF]);
		fb.set[FLG_WAKE]  = wake_evt;
		fb.set[FLG_RESET] = usb_reset_evt;
		fb.set[FLG_SOF]   = sof_evt;
		fb.clr = 8'h00;
		if (wr_access && paddr == OFS_FLAGS)
			fb.clr = ~wdata;
	end

	// Link state: forced reset dominates, then forced sleep
	always_comb
	begin
		case (state)
			ST_ACTIVE: next_state = link_control_reg[CTL_SLEEP]
				? ST_SLEEP : ST_ACTIVE;
			ST_SLEEP:  next_state = activity || !link_control_reg[CTL_SLEEP]
				? ST_ACTIVE : ST_SLEEP;
			ST_RESET:  next_state = ST_ACTIVE;
			default:   next_state = ST_ACTIVE;
		endcase
		if (link_control_reg[CTL_FORCED_BUS_RESET])
			next_state = ST_RESET;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= ST_ACTIVE;
		else
			state <= next_state;
	end

	// Idle check: armed by any reset or resume end, dropped by sleep
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			idle_armed  <= 1'b1;
			resume_prev <= 1'b0;
		end
		else
		begin
			resume_prev <= link_control_reg[CTL_RESUME];
			if (usb_reset_evt || resume_end)
				idle_armed <= 1'b1;
			else if (link_control_reg[CTL_SLEEP])
				idle_armed <= 1'b0;
		end
	end

	// Late DMA: a request left ungranted for the wait limit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dma_wait     <= 4'h0;
			dma_late_evt <= 1'b0;
		end
		else
		begin
			dma_late_evt <= 1'b0;
			if (!dma_request || dma_grant)
				dma_wait <= 4'h0;
			else if (dma_wait != DMA_WAIT_CYCLES)
			begin
				dma_wait     <= dma_wait + 4'h1;
				dma_late_evt <= (dma_wait == DMA_WAIT_CYCLES - 4'h1);
			end
		end
	end

	// Buffer base registers; low six bits come from the engine
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dma_base_high_reg <= RST_DMA;
			buffer_base_bits  <= 2'h0;
			dma_addr          <= 16'h0000;
		end
		else
		begin
			if (wr_access && paddr == OFS_DMA_HIGH)
				dma_base_high_reg <= wdata;
			if (wr_access && paddr == OFS_DMA_LOW)
				buffer_base_bits <= wdata[7:6];
			// Offset above the 48-byte area is the engine's to avoid
			dma_addr <= {dma_base_high_reg, buffer_base_bits,
				dma_offset};
		end
	end

	// Transfer report, taken together so software sees one set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			endpoint_number     <= 2'h0;
			received_byte_count <= 4'h0;
			token_pid_high      <= 2'h0;
		end
		else if (ok_evt)
		begin
			endpoint_number <= xfer_ep;
			token_pid_high  <= xfer_pid_high;
			if (xfer_is_rx)
				received_byte_count <= xfer_count;
		end
	end

	// Mask, control and node address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			event_mask_reg   <= RST_MASK;
			link_control_reg <= RST_CONTROL;
			node_id_reg      <= RST_NODE_ID;
		end
		else
		begin
			if (wr_access && paddr == OFS_MASK)
				event_mask_reg <= wdata;
			if (wr_access && paddr == OFS_CONTROL)
				link_control_reg <= wdata[3:0];
			if (wake_evt)
				link_control_reg[CTL_SLEEP] <= 1'b0;
			if (link_control_reg[CTL_FORCED_BUS_RESET] || bus_reset_seen)
				node_id_reg <= RST_NODE_ID;
			else if (wr_access && paddr == OFS_NODE_ID)
				node_id_reg <= wdata[6:0];
		end
	end

	// Transmit endpoint control with hardware handshake updates
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NUM_EP; i++)
				tx_endpoint_control_reg[i] <= RST_EP_TX;
		end
		else
		begin
			for (int i = 0; i < NUM_EP; i++)
			begin
				if (link_control_reg[CTL_FORCED_BUS_RESET] || bus_reset_seen)
					tx_endpoint_control_reg[i] <= RST_EP_TX;
				else if (ok_evt && xfer_ep == 2'(i)
					&& (xfer_pid_high == PID_IN
					|| xfer_pid_high == PID_SETUP))
				begin
					tx_endpoint_control_reg[i][5:4] <= STAT_NAK;
					tx_endpoint_control_reg[i][6] <=
						(xfer_pid_high == PID_SETUP)
						|| !tx_endpoint_control_reg[i][6];
				end
				else if (wr_access && ep_slot(paddr) == 2'(i))
					tx_endpoint_control_reg[i] <= {1'b0, wdata[6:0]};
			end
		end
	end

	// Read mux, sampled in the setup phase
	always_comb
	begin
		next_rdata = 32'h00000000;
		next_err   = 1'b0;
		case (paddr)
			OFS_DMA_HIGH: next_rdata[7:0] = dma_base_high_reg;
			OFS_DMA_LOW:  next_rdata[7:0] = {buffer_base_bits,
				endpoint_number, received_byte_count};
			OFS_TOKEN:    next_rdata[7:0] = {token_pid_high, 3'h0,
				line_se0, line_k, 1'b0};
			OFS_FLAGS:    next_rdata[7:0] = fb.flags;
			OFS_MASK:     next_rdata[7:0] = event_mask_reg;
			OFS_CONTROL:  next_rdata[7:0] = {4'h0, link_control_reg};
			OFS_NODE_ID:  next_rdata[7:0] = {1'b0, node_id_reg};
			OFS_EP0_TX:   next_rdata[7:0] = tx_endpoint_control_reg[0];
			OFS_EP1_TX:   next_rdata[7:0] = tx_endpoint_control_reg[1];
			OFS_EP2_TX:   next_rdata[7:0] = tx_endpoint_control_reg[2];
			default:      next_err = 1'b1;
		endcase
	end

	// Zero-wait answer: ready rises for exactly the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= rd_setup;
			pslverr <= rd_setup && next_err;
			if (rd_setup)
				prdata <= pwrite ? 32'h00000000 : next_rdata;
		end
	end

	// Interrupt lines and link outputs, all registered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_req       <= 1'b0;
			wake_irq      <= 1'b0;
			resume_drive  <= 1'b0;
			regulator_off <= 1'b1;
			suspended     <= 1'b0;
			iface_reset   <= 1'b0;
		end
		else
		begin
			irq_req <= |(fb.flags & event_mask_reg) && !cpu_imask;
			// Separate wake line so a halted processor can be roused
			wake_irq <= fb.flags[FLG_WAKE] && event_mask_reg[FLG_WAKE];
			resume_drive  <= link_control_reg[CTL_RESUME];
			regulator_off <= link_control_reg[CTL_REGULATOR_OFF];
			suspended     <= (state == ST_SLEEP);
			iface_reset   <= (state == ST_RESET) || bus_reset_seen;
		end
	end

	assign node_id    = node_id_reg;
	assign ep_tx_ctrl = {tx_endpoint_control_reg[2],
		tx_endpoint_control_reg[1], tx_endpoint_control_reg[0]};

	sequence s_release;
		$fell(link_control_reg[CTL_FORCED_BUS_RESET]);
	endsequence
	sequence s_reset_flag;
		##1 fb.flags[FLG_RESET];
	endsequence

	property p_dma_addr;
		@(posedge pclk) disable iff (!presetn)
		##1 dma_addr == {$past(dma_base_high_reg),
			$past(buffer_base_bits), $past(dma_offset)};
	endproperty
	a_dma_addr: assert property (p_dma_addr)
		else $error("buffer address does not follow base and offset");

	property p_report;
		@(posedge pclk) disable iff (!presetn)
		ok_evt |=> endpoint_number == $past(xfer_ep)
			&& token_pid_high == $past(xfer_pid_high)
			&& fb.flags[FLG_OK];
	endproperty
	a_report: assert property (p_report)
		else $error("transfer report not updated with its flag");

	property p_ok_clean;
		@(posedge pclk) disable iff (!presetn)
		(xfer_done && (answered_nak_stall || fault_crc || fault_toggle))
			|-> !fb.set[FLG_OK];
	endproperty
	a_ok_clean: assert property (p_ok_clean)
		else $error("faulty transfer marked correct");

	property p_err;
		@(posedge pclk) disable iff (!presetn)
		fault_timeout |=> fb.flags[FLG_ERR];
	endproperty
	a_err: assert property (p_err)
		else $error("timeout did not raise the error flag");

	property p_overrun;
		@(posedge pclk) disable iff (!presetn)
		(err_evt && fb.flags[FLG_ERR]) |=> fb.flags[FLG_OVR];
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("pending error hit without overrun flag");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		##1 irq_req == ($past(|(fb.flags & event_mask_reg))
			&& !$past(cpu_imask));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request disagrees with flags and mask");

	property p_forced_bus_reset_release;
		@(posedge pclk) disable iff (!presetn)
		s_release |-> s_reset_flag;
	endproperty
	a_forced_bus_reset_release: assert property (p_forced_bus_reset_release)
		else $error("forced reset release raised no reset flag");

	property p_nak;
		@(posedge pclk) disable iff (!presetn)
		(ok_evt && xfer_ep == 2'h0 && xfer_pid_high == PID_IN
			&& !link_control_reg[CTL_FORCED_BUS_RESET] && !bus_reset_seen)
			|=> tx_endpoint_control_reg[0][5:4] == STAT_NAK;
	endproperty
	a_nak: assert property (p_nak)
		else $error("correct IN did not set transmit NAK");

	property p_wake;
		@(posedge pclk) disable iff (!presetn)
		wake_evt |=> fb.flags[FLG_WAKE] && !link_control_reg[CTL_SLEEP];
	endproperty
	a_wake: assert property (p_wake)
		else $error("activity in sleep not handled");

	property p_node_reset;
		@(posedge pclk) disable iff (!presetn)
		bus_reset_seen |=> node_id == RST_NODE_ID && fb.flags[FLG_RESET];
	endproperty
	a_node_reset: assert property (p_node_reset)
		else $error("bus reset left node address or flag");
endmodule : usb_fn_regs

/* File: usb_host_model.sv */
// Far-side model: bus line pins and serial engine reports
module usb_host_model
(
	// Clock
	input  wire logic pclk,
	// Line pins
	output logic       se0,
	output logic       kst,
	// Transaction report
	output logic       done,
	output logic [1:0] ep,
	output logic [1:0] pid,
	output logic [3:0] cnt,
	output logic       rx,
	output logic [6:0] flt,
	// Events: timeout, bus reset, keep-alive
	output logic [2:0] ev
);
	timeunit 1ns;
	timeprecision 1ns;
	// Quiet, idle bus at time zero
	initial
	begin
		{se0, kst, done, ev} = '0;
		{ep, pid, cnt, rx, flt} = '0;
	end
	// Fields mean something only with done; afterwards ep, pid, cnt and flt show the
	// inverse and rx drops to 0, so a late sample inside the block cannot pass by luck
	task send(input logic [1:0] e, input logic [1:0] p,
		input logic [3:0] c, input logic [6:0] f);
		@(posedge pclk);
		// An IN token means the device transmits, so no reception count
		{done, ep, pid, cnt, rx, flt} <= {1'b1, e, p, c, p != 2'h2, f};
		@(posedge pclk);
		{done, ep, pid, cnt, rx, flt} <= {1'b0, ~e, ~p, ~c, 1'b0, ~f};
	endtask : send
	// One-cycle event strobe
	task pulse(input logic [2:0] e);
		@(posedge pclk);
		ev <= e;
		@(posedge pclk);
		ev <= 3'h0;
	endtask : pulse
	// Line state; the block syncs it, so callers allow a few cycles
	task line(input logic s, input logic k);
		@(posedge pclk);
		se0 <= s;
		kst <= k;
	endtask : line
endmodule : usb_host_model

/* File: tb.sv */
// Self-checking bench for the function register block
module tb
	import usb_fn_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [5:0]  dma_offset = 6'h00;
	logic        dma_request = 1'b0;
	logic        dma_grant = 1'b0;
	logic        cpu_imask = 1'b0;
	logic        se0, kst, done, rx, pready, pslverr, err;
	logic [1:0]  ep, pid;
	logic [3:0]  cnt;
	logic [6:0]  flt, node_id;
	logic [2:0]  ev;
	logic [31:0] prdata, q;
	logic [15:0] dma_addr;
	logic [23:0] ep_tx_ctrl;
	logic        irq_req, wake_irq, resume_drive;
	logic        regulator_off, suspended, iface_reset;
	int          miscompares = 0;
	int          n_tests = 0;
	// Expected endpoint, token, count and register after each transfer
	logic [1:0]  t_ep [3] = '{2'h1, 2'h2, 2'h0};
	logic [1:0]  t_pid [3] = '{PID_IN, PID_SETUP, 2'h0};
	logic [3:0]  t_cnt [3] = '{4'h5, 4'h3, 4'h8};
	// An IN is a transmission, so the count keeps the last reception
	logic [3:0]  t_rxc [3] = '{4'h0, 4'h3, 4'h8};
	logic [7:0]  t_reg [3] = '{8'h63, 8'h60, 8'h00};

	// Short idle limit so idle detection fits the run
	usb_fn_regs #(.IDLE_LIMIT(20)) usb_fn_regs_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .line_se0_pin(se0),
		.line_k_pin(kst), .xfer_done(done), .xfer_ep(ep),
		.xfer_pid_high(pid), .xfer_count(cnt), .xfer_is_rx(rx),
		.fault_pid(flt[6]), .fault_crc(flt[5]), .fault_toggle(flt[4]),
		.fault_overrun(flt[3]), .fault_stuff(flt[2]),
		.fault_frame(flt[1]), .answered_nak_stall(flt[0]),
		.fault_timeout(ev[2]), .bus_reset_seen(ev[1]),
		.keepalive(ev[0]), .dma_offset(dma_offset),
		.dma_request(dma_request), .dma_grant(dma_grant),
		.dma_addr(dma_addr), .cpu_imask(cpu_imask), .irq_req(irq_req),
		.wake_irq(wake_irq), .resume_drive(resume_drive),
		.regulator_off(regulator_off), .suspended(suspended),
		.iface_reset(iface_reset), .node_id(node_id),
		.ep_tx_ctrl(ep_tx_ctrl));
	usb_host_model usb_host_model_inst (
		.pclk(pclk), .se0(se0), .kst(kst), .done(done), .ep(ep),
		.pid(pid), .cnt(cnt), .rx(rx), .flt(flt), .ev(ev));

	// Free-running bus clock, 50 ns period
	initial
	begin
		forever #25 pclk = ~pclk;
	end
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	// APB transfer; an idle cycle follows so psel never changes twice
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : bus
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	// Read a register and compare the bits under m
	task rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk($sformatf("reg %h", a), q & {24'h0, m}, {24'h0, e});
	endtask : rc
	task final_report;
		$display("checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	// Watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		final_report;
	end
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rc(OFS_FLAGS, 8'hFF, RST_FLAGS);
		rc(OFS_MASK, 8'hFF, RST_MASK);
		rc(OFS_CONTROL, 8'hFF, 8'h06);
		for (int i = 0; i < 4; i++)
			rc(OFS_NODE_ID + 8'(4 * i), 8'hFF, 8'h00);
		chk("regulator_off", regulator_off, 1);
		chk("suspended", suspended, 1);
		bus(1'b1, 8'h28, 8'h5A);
		chk("pslverr", err, 1);
		bus(1'b0, 8'h28, 8'h00);
		chk("unmapped", q, 0);
		$display("test reset done");
		// Activity while asleep wakes the link; live line bits follow
		bus(1'b1, OFS_MASK, 8'h04);
		usb_host_model_inst.line(1'b1, 1'b0);
		cyc(4);
		rc(OFS_TOKEN, 8'h3F, 8'h04);
		usb_host_model_inst.line(1'b0, 1'b1);
		cyc(4);
		rc(OFS_TOKEN, 8'h3F, 8'h02);
		usb_host_model_inst.line(1'b0, 1'b0);
		rc(OFS_FLAGS, 8'h04, 8'h04);
		rc(OFS_CONTROL, 8'hFF, 8'h04);
		chk("wake_irq", wake_irq, 1);
		$display("test wake done");
		// Bus reset clears address and endpoints, then idle is armed
		bus(1'b1, OFS_NODE_ID, 8'hFF);
		rc(OFS_NODE_ID, 8'hFF, 8'h7F);
		bus(1'b1, OFS_EP1_TX, 8'h33);
		usb_host_model_inst.pulse(3'h2);
		rc(OFS_FLAGS, 8'h82, 8'h02);
		rc(OFS_NODE_ID, 8'hFF, 8'h00);
		rc(OFS_EP1_TX, 8'hFF, 8'h00);
		cyc(40);
		rc(OFS_FLAGS, 8'h80, 8'h80);
		bus(1'b1, OFS_FLAGS, 8'h00);
		bus(1'b1, OFS_FLAGS, 8'hFF);
		rc(OFS_FLAGS, 8'hFF, 8'h00);
		$display("test bus reset done");
		// Clean transfers on every endpoint, with IN, SETUP and code 0 tokens
		bus(1'b1, OFS_EP1_TX, 8'h33);
		for (int i = 0; i < 3; i++)
		begin
			usb_host_model_inst.send(t_ep[i], t_pid[i], t_cnt[i], 7'h00);
			rc(OFS_FLAGS, 8'h20, 8'h20);
			rc(OFS_DMA_LOW, 8'h3F,
				{2'h0, t_ep[i], t_rxc[i]});
			rc(OFS_TOKEN, 8'hC0, {t_pid[i], 6'h00});
			rc(OFS_EP0_TX + 8'(4 * t_ep[i]), 8'hFF, t_reg[i]);
			chk("ep_tx_ctrl", ep_tx_ctrl[8 * t_ep[i] +: 8], t_reg[i]);
			bus(1'b1, OFS_FLAGS, 8'hDF);
			rc(OFS_FLAGS, 8'h20, 8'h00);
		end
		// Each transfer fault but timeout, or a NAK/STALL answer, leaves transfer-ok clear
		for (int i = 0; i < 7; i++)
		begin
			usb_host_model_inst.send(2'h1, PID_IN, 4'h2, 7'(1 << i));
			rc(OFS_FLAGS, 8'h20, 8'h00);
		end
		$display("test transfer done");
		// Error then timeout while pending gives overrun; same for frames
		bus(1'b1, OFS_FLAGS, 8'h00);
		usb_host_model_inst.send(2'h0, 2'h0, 4'h1, 7'h20);
		rc(OFS_FLAGS, 8'h18, 8'h10);
		usb_host_model_inst.pulse(3'h4);
		rc(OFS_FLAGS, 8'h18, 8'h18);
		bus(1'b1, OFS_FLAGS, 8'h00);
		usb_host_model_inst.pulse(3'h1);
		rc(OFS_FLAGS, 8'h09, 8'h01);
		usb_host_model_inst.pulse(3'h1);
		rc(OFS_FLAGS, 8'h09, 8'h09);
		$display("test error done");
		// Interrupt request follows flag, mask and processor mask
		bus(1'b1, OFS_FLAGS, 8'h00);
		bus(1'b1, OFS_MASK, 8'h20);
		usb_host_model_inst.send(2'h0, 2'h0, 4'h1, 7'h00);
		cyc(2);
		chk("irq_req", irq_req, 1);
		cpu_imask <= 1'b1;
		cyc(2);
		chk("irq_req", irq_req, 0);
		cpu_imask <= 1'b0;
		bus(1'b1, OFS_FLAGS, 8'h00);
		cyc(2);
		chk("irq_req", irq_req, 0);
		$display("test irq done");
		// DMA address and late service
		bus(1'b1, OFS_DMA_HIGH, 8'hAB);
		bus(1'b1, OFS_DMA_LOW, 8'h00);
		dma_offset <= 6'h15;
		cyc(3);
		chk("dma_addr", dma_addr, 16'hAB15);
		dma_request <= 1'b1;
		dma_grant <= 1'b1;
		cyc(12);
		rc(OFS_FLAGS, 8'h40, 8'h00);
		dma_grant <= 1'b0;
		cyc(12);
		dma_request <= 1'b0;
		rc(OFS_FLAGS, 8'h40, 8'h40);
		$display("test dma done");
		// Resume, regulator and forced reset controls
		bus(1'b1, OFS_FLAGS, 8'h00);
		bus(1'b1, OFS_CONTROL, 8'h08);
		// Outputs are registered one edge after the write lands
		cyc(1);
		chk("resume_drive", resume_drive, 1);
		chk("regulator_off", regulator_off, 0);
		bus(1'b1, OFS_CONTROL, 8'h00);
		rc(OFS_FLAGS, 8'h01, 8'h01);
		bus(1'b1, OFS_NODE_ID, 8'h12);
		bus(1'b1, OFS_CONTROL, 8'h01);
		// Link state, then the registered reset output, follow the write
		cyc(2);
		chk("iface_reset", iface_reset, 1);
		chk("node_id", node_id, 0);
		rc(OFS_FLAGS, 8'h02, 8'h00);
		bus(1'b1, OFS_CONTROL, 8'h00);
		cyc(2);
		rc(OFS_FLAGS, 8'h02, 8'h02);
		$display("test control done");
		final_report;
	end
endmodule : tb
